// *** verilog/psd_core.sv ***
// status collection and display configuration registers behind an Avalon-MM slave
//
// Overview of operation
// - memory-test flag set only when the power-up self-test passes
// - incompatibility flag set when controller or array mismatches firmware
// - secondary-present flag set when second controller present and ready
// - init-complete flag set only after all init steps finish successfully
// - reset-waveform error flag set on overlapping bias or reset operations
// - video mode short back porch forces buffer swap and sets flag
// - video-fed pattern mode misaligned with vsync sets forced-swap flag
// - sequence-abort flag set on every abort; host re-reads to confirm
// - sequence-error flag set on every sequence error; host re-reads
// - parked flag held while micromirror array stays parked
// - sequencer-running and video-running flags follow their conditions
// - source-lock flag follows lock, clears at once on loss
// - switch into video-fed pattern mode refused without locked source
// - east-west flip mirrors long axis, north-south mirrors short axis
// - light enables manual or automatic; per-colour current applied
// - pwm-invert setting inverts light-source current control polarity
// - colour channels of selected port reordered; ABC->BAC swaps red/green
// - single-pixel or dual-pixel input mode selectable
// - display source chosen among parallel, test pattern, flash, curtain
// - test pattern uses programmable foreground and background colours
// - display and cropped windows programmable for scale and crop
// - receiver selects connector; power-down releases its outputs
`default_nettype none
module psd_core
	import psd_pkg::*;
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        reset,
	// avalon-mm slave
	input  wire logic [5:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest,
	// controller conditions
	input  wire psd_cond_t   cond,
	input  wire logic        seq_auto_red,
	input  wire logic        seq_auto_green,
	input  wire logic        seq_auto_blue,
	// display configuration out
	output logic             flip_long_axis,
	output logic             flip_short_axis,
	output logic             force_swap,
	output logic [2:0]       light_enable,
	output psd_rgb_t         light_current,
	output logic             invert_data,
	output psd_source_t      display_source,
	output psd_mode_t        op_mode,
	output logic [1:0]       input_port,
	output psd_swap_t        channel_swap,
	output logic             dual_pixel,
	output psd_rgb_t         tp_foreground,
	output psd_rgb_t         tp_background,
	output psd_window_t      disp_window,
	output psd_window_t      crop_window,
	output logic             rx_connector,
	output logic             rx_power_down,
	output logic             rx_out_en_n
);
	////////////////////////////////////////////////////////////////////////
	// bus handshake: one wait cycle, answer on the second edge
	logic        ack;
	logic        wr_ok;
	logic        rd_ok;
	logic [ST_WIDTH-1:0] status;
	logic        light_auto;
	logic [2:0]  light_manual;
	logic        pwm_invert;
	logic        refused;

	// byte-enable merge used only by the light current register
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
		begin
			if (be[i])
				r[i*8 +: 8] = nw[i*8 +: 8];
		end
		return r;
	endfunction

	assign avs_waitrequest = (avs_read | avs_write) & ~ack;
	assign wr_ok = avs_write & ack;
	assign rd_ok = avs_read & ~ack;

	// ack pulses for one cycle after a request is seen
	always_ff @(posedge clk)
	begin
		if (reset)
			ack <= 1'b0;
		else
			ack <= (avs_read | avs_write) & ~ack;
	end

	////////////////////////////////////////////////////////////////////////
	// status flags; live levels other than lock follow their causes with one cycle of lag
	logic       flag_memtest;
	logic       flag_incompat;
	logic       flag_second;
	logic       flag_initdone;
	logic       flag_parked;
	logic       flag_seqrun;
	logic       flag_vidrun;
	logic [3:0] flag_sticky;   // rsterr at bit 0 up to seqerr at bit 3

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			flag_memtest  <= 1'b0;
			flag_incompat <= 1'b0;
			flag_second   <= 1'b0;
			flag_initdone <= 1'b0;
			flag_parked   <= 1'b0;
			flag_seqrun   <= 1'b0;
			flag_vidrun   <= 1'b0;
		end
		else
		begin
			if (cond.memtest_done)
				flag_memtest <= cond.memtest_pass;
			flag_incompat <= cond.ctrl_mismatch | cond.array_mismatch;
			flag_second   <= cond.dual_config & cond.second_ready;
			flag_initdone <= cond.init_steps_done & cond.init_steps_ok;
			flag_parked   <= cond.array_parked;
			flag_seqrun   <= cond.seq_running;
			flag_vidrun   <= cond.video_ok;
		end
	end

	// short back porch in video mode
	// vsync misalignment in video-fed pattern mode
	logic swap_cause;
	assign swap_cause = (op_mode == PSD_MODE_VIDEO && cond.short_back_porch)
		|| (op_mode == PSD_MODE_VIDPAT && cond.vsync_misalign);

	// the swap follows its cause; the sticky flag keeps the evidence for the host
	always_ff @(posedge clk)
	begin
		if (reset)
			force_swap <= 1'b0;
		else
			force_swap <= swap_cause;
	end

	// sticky event flags: write ones to the clear register to drop them; a set wins
	logic       clr_hit;
	logic [3:0] clr_mask;
	logic [3:0] sticky_set;
	assign clr_hit  = wr_ok && avs_address == OFS_CLEAR;
	assign clr_mask = clr_hit ? avs_writedata[ST_SEQERR:ST_RSTERR] : 4'h0;
	// abort may be transient, so host clears and re-reads
	assign sticky_set = {cond.seq_error, cond.seq_abort, swap_cause, cond.reset_overlap};

	always_ff @(posedge clk)
	begin
		if (reset)
			flag_sticky <= 4'h0;
		else
			flag_sticky <= sticky_set | (flag_sticky & ~clr_mask);
	end

	// lock follows source directly, even in reset
	// every indicator gathered in one word
	always_comb
	begin
		status                      = '0;
		status[ST_MEMTEST]          = flag_memtest;
		status[ST_INCOMPAT]         = flag_incompat;
		status[ST_SECOND]           = flag_second;
		status[ST_INITDONE]         = flag_initdone;
		status[ST_SEQERR:ST_RSTERR] = flag_sticky;
		status[ST_PARKED]           = flag_parked;
		status[ST_SEQRUN]           = flag_seqrun;
		status[ST_VIDRUN]           = flag_vidrun;
		status[ST_LOCK]             = cond.source_locked;
		status[ST_MODEREF]          = refused;
	end

	////////////////////////////////////////////////////////////////////////
	// configuration registers written by software
	// flips
	// data inversion, host keeps the sequence stopped
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			flip_long_axis  <= 1'b0;
			flip_short_axis <= 1'b0;
			invert_data     <= 1'b0;
		end
		else if (wr_ok && avs_address == OFS_ORIENT && avs_byteenable[0])
		begin
			flip_long_axis  <= avs_writedata[0];
			flip_short_axis <= avs_writedata[1];
			invert_data     <= avs_writedata[2];
		end
	end

	// drive word is held inverted while pwm invert is on; software sees the setting
	logic [23:0] current_setting;
	logic [31:0] merged_current;
	assign current_setting = light_current ^ {24{pwm_invert}};
	assign merged_current  = merge({8'h00, current_setting}, avs_writedata, avs_byteenable);

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			light_auto    <= 1'b1;
			light_manual  <= 3'h7;
			pwm_invert    <= 1'b0;
			light_current <= {CURRENT_RST, CURRENT_RST, CURRENT_RST};
		end
		else if (wr_ok && avs_address == OFS_LIGHT && avs_byteenable[0])
		begin
			light_manual <= avs_writedata[2:0];
			light_auto   <= avs_writedata[3];
			pwm_invert   <= avs_writedata[4];
			// the drive word flips whenever the polarity setting changes
			if (avs_writedata[4] != pwm_invert)
				light_current <= ~light_current;
		end
		else if (wr_ok && avs_address == OFS_CURRENT)
		begin
			light_current <= merged_current[23:0] ^ {24{pwm_invert}};
		end
	end

	// enables chosen from sequencer or host
	assign light_enable = light_auto ? {seq_auto_blue, seq_auto_green, seq_auto_red}
		: light_manual;

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			display_source <= PSD_SRC_PARALLEL;
			input_port     <= 2'h0;
			channel_swap   <= PSD_SWAP_BAC;
			dual_pixel     <= 1'b0;
			rx_connector   <= 1'b0;
			rx_power_down  <= 1'b0;
		end
		else if (wr_ok && avs_address == OFS_SOURCE && avs_byteenable[0])
		begin
			display_source <= psd_source_t'(avs_writedata[1:0]);
		end
		else if (wr_ok && avs_address == OFS_PORTCFG && avs_byteenable[0])
		begin
			input_port    <= avs_writedata[1:0];
			if (avs_writedata[4:2] <= 3'h5)
				channel_swap <= psd_swap_t'(avs_writedata[4:2]);
			dual_pixel    <= avs_writedata[5];
			rx_connector  <= avs_writedata[6];
			rx_power_down <= avs_writedata[7];
		end
	end

	// receiver outputs released when powered down
	assign rx_out_en_n = rx_power_down;

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			tp_foreground <= '0;
			tp_background <= '0;
			disp_window   <= '0;
			crop_window   <= '0;
		end
		else if (wr_ok)
		begin
			unique case (avs_address)
				OFS_TP_FORE: tp_foreground <= psd_rgb_t'(avs_writedata[23:0]);
				OFS_TP_BACK: tp_background <= psd_rgb_t'(avs_writedata[23:0]);
				OFS_DISP_H:  disp_window[63:32] <= avs_writedata;
				OFS_DISP_V:  disp_window[31:0]  <= avs_writedata;
				OFS_CROP_H:  crop_window[63:32] <= avs_writedata;
				OFS_CROP_V:  crop_window[31:0]  <= avs_writedata;
				default: ;
			endcase
		end
	end

	// video-fed pattern mode needs lock; refusal is flagged
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			op_mode <= PSD_MODE_VIDEO;
			refused <= 1'b0;
		end
		else if (wr_ok && avs_address == OFS_MODE && avs_byteenable[0])
		begin
			if (avs_writedata[1:0] == PSD_MODE_VIDPAT && !cond.source_locked)
				refused <= 1'b1;
			else
			begin
				op_mode <= psd_mode_t'(avs_writedata[1:0]);
				refused <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read mux; data registered so it stands at the ack edge
	// status word read
	always_ff @(posedge clk)
	begin
		if (reset)
			avs_readdata <= READ_ZERO;
		else if (rd_ok)
		begin
			unique case (avs_address)
				OFS_STATUS:  avs_readdata <= {{(32-ST_WIDTH){1'b0}}, status};
				OFS_ORIENT:  avs_readdata <= {29'h0, invert_data, flip_short_axis,
					flip_long_axis};
				OFS_LIGHT:   avs_readdata <= {27'h0, pwm_invert, light_auto, light_manual};
				OFS_CURRENT: avs_readdata <= {8'h00, current_setting};
				OFS_SOURCE:  avs_readdata <= {30'h0, display_source};
				OFS_PORTCFG: avs_readdata <= {24'h0, rx_power_down, rx_connector, dual_pixel,
					channel_swap, input_port};
				OFS_TP_FORE: avs_readdata <= {8'h00, tp_foreground};
				OFS_TP_BACK: avs_readdata <= {8'h00, tp_background};
				OFS_DISP_H:  avs_readdata <= disp_window[63:32];
				OFS_DISP_V:  avs_readdata <= disp_window[31:0];
				OFS_CROP_H:  avs_readdata <= crop_window[63:32];
				OFS_CROP_V:  avs_readdata <= crop_window[31:0];
				OFS_MODE:    avs_readdata <= {30'h0, op_mode};
				default:     avs_readdata <= READ_ZERO;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	a_lock_follows: assert property (@(posedge clk) disable iff (reset)
		status[ST_LOCK] == cond.source_locked)
		else $error("lock flag differs from source lock");
	a_abort_sticky: assert property (@(posedge clk) disable iff (reset)
		cond.seq_abort |=> status[ST_ABORT])
		else $error("abort flag not set");
	a_err_sticky: assert property (@(posedge clk) disable iff (reset)
		cond.seq_error |=> status[ST_SEQERR])
		else $error("sequence error flag not set");
	a_overlap_flag: assert property (@(posedge clk) disable iff (reset)
		cond.reset_overlap |=> status[ST_RSTERR])
		else $error("overlap flag not set");
	a_mode_refused: assert property (@(posedge clk) disable iff (reset)
		(wr_ok && avs_address == OFS_MODE && avs_byteenable[0]
		&& avs_writedata[1:0] == PSD_MODE_VIDPAT && !cond.source_locked)
		|=> op_mode == $past(op_mode) && refused)
		else $error("mode switch taken without lock");
	a_swap_video: assert property (@(posedge clk) disable iff (reset)
		(op_mode == PSD_MODE_VIDEO && cond.short_back_porch) |=> force_swap && status[ST_FSWAP])
		else $error("forced swap missing");
	a_init_done: assert property (@(posedge clk) disable iff (reset)
		status[ST_INITDONE] |-> $past(cond.init_steps_done && cond.init_steps_ok))
		else $error("init flag without success");
	a_light_manual: assert property (@(posedge clk) disable iff (reset)
		!light_auto |-> light_enable == light_manual)
		else $error("manual light enables not applied");
	a_wait_once: assert property (@(posedge clk) disable iff (reset)
		(avs_read && !ack) |=> !avs_waitrequest)
		else $error("waitrequest held too long");
endmodule // psd_core
`default_nettype wire

// *** verilog/psd_pkg.sv ***
// constants, register map and carrier types of the status and display configuration block
`default_nettype none
package psd_pkg;
	// register byte offsets (word aligned)
	localparam logic [5:0] OFS_STATUS    = 6'h00;
	localparam logic [5:0] OFS_ORIENT    = 6'h04;
	localparam logic [5:0] OFS_LIGHT     = 6'h08;
	localparam logic [5:0] OFS_CURRENT   = 6'h0C;
	localparam logic [5:0] OFS_SOURCE    = 6'h10;
	localparam logic [5:0] OFS_PORTCFG   = 6'h14;
	localparam logic [5:0] OFS_TP_FORE   = 6'h18;
	localparam logic [5:0] OFS_TP_BACK   = 6'h1C;
	localparam logic [5:0] OFS_DISP_H    = 6'h20;
	localparam logic [5:0] OFS_DISP_V    = 6'h24;
	localparam logic [5:0] OFS_CROP_H    = 6'h28;
	localparam logic [5:0] OFS_CROP_V    = 6'h2C;
	localparam logic [5:0] OFS_MODE      = 6'h30;
	localparam logic [5:0] OFS_CLEAR     = 6'h34;
	// status word bit positions
	localparam int ST_MEMTEST  = 0;
	localparam int ST_INCOMPAT = 1;
	localparam int ST_SECOND   = 2;
	localparam int ST_INITDONE = 3;
	localparam int ST_RSTERR   = 4;
	localparam int ST_FSWAP    = 5;
	localparam int ST_ABORT    = 6;
	localparam int ST_SEQERR   = 7;
	localparam int ST_PARKED   = 8;
	localparam int ST_SEQRUN   = 9;
	localparam int ST_VIDRUN   = 10;
	localparam int ST_LOCK     = 11;
	localparam int ST_MODEREF  = 12;
	localparam int ST_WIDTH    = 13;
	// reset values
	localparam logic [7:0]  CURRENT_RST = 8'h64;
	localparam logic [31:0] READ_ZERO   = 32'h0000_0000;
	// display source choices
	typedef enum logic [1:0] {
		PSD_SRC_PARALLEL = 2'b00,
		PSD_SRC_TESTPAT  = 2'b01,
		PSD_SRC_FLASH    = 2'b10,
		PSD_SRC_CURTAIN  = 2'b11
	} psd_source_t;
	// operating modes
	typedef enum logic [1:0] {
		PSD_MODE_VIDEO   = 2'b00,
		PSD_MODE_PATTERN = 2'b01,
		PSD_MODE_VIDPAT  = 2'b10,
		PSD_MODE_OTF     = 2'b11
	} psd_mode_t;
	// colour channel ordering
	typedef enum logic [2:0] {
		PSD_SWAP_ABC = 3'b000,
		PSD_SWAP_BAC = 3'b001,
		PSD_SWAP_ACB = 3'b010,
		PSD_SWAP_CBA = 3'b011,
		PSD_SWAP_BCA = 3'b100,
		PSD_SWAP_CAB = 3'b101
	} psd_swap_t;
	// one colour triple
	typedef struct packed {
		logic [7:0] red;
		logic [7:0] green;
		logic [7:0] blue;
	} psd_rgb_t;
	// one window of the display dimensions
	typedef struct packed {
		logic [15:0] start_pixel;
		logic [15:0] pixels_per_line;
		logic [15:0] start_line;
		logic [15:0] lines_per_frame;
	} psd_window_t;
	// raw condition inputs from the controller core
	typedef struct packed {
		logic memtest_pass;
		logic memtest_done;
		logic ctrl_mismatch;
		logic array_mismatch;
		logic dual_config;
		logic second_ready;
		logic init_steps_done;
		logic init_steps_ok;
		logic reset_overlap;
		logic short_back_porch;
		logic vsync_misalign;
		logic seq_abort;
		logic seq_error;
		logic array_parked;
		logic seq_running;
		logic video_ok;
		logic source_locked;
	} psd_cond_t;
endpackage : psd_pkg
`default_nettype wire

// *** tb/psd_host_model.sv ***
// avalon-mm host model issuing register reads and writes on behalf of the bench
`default_nettype none
module psd_host_model
(
	// clock
	input  wire logic        clk,
	// avalon-mm master side
	output logic [5:0]       avs_address,
	output logic             avs_read,
	output logic             avs_write,
	output logic [31:0]      avs_writedata,
	output logic [3:0]       avs_byteenable,
	input  wire logic [31:0] avs_readdata,
	input  wire logic        avs_waitrequest
);
	timeunit 1ns;
	timeprecision 1ps;

	////////////////////////////////////////////////////////////////////////////////
	// idle bus at time zero, all lanes enabled
	initial
	begin
		avs_address    = 6'h00;
		avs_read       = 1'b0;
		avs_write      = 1'b0;
		avs_writedata  = 32'h0000_0000;
		avs_byteenable = 4'hF;
	end

	////////////////////////////////////////////////////////////////////////////////
	// hold request until waitrequest is sampled low; only the bench timeout ends a stuck wait
	// read data is taken at that same edge, before anything is released
	task automatic finish_req(output logic [31:0] d);
		@(posedge clk);
		while (avs_waitrequest !== 1'b0)
			@(posedge clk);
		d = avs_readdata;
		avs_read      <= 1'b0;
		avs_write     <= 1'b0;
		avs_address   <= ~avs_address;   // released lines show no stale value
		avs_writedata <= ~avs_writedata;
	endtask

	// one write; an edge passes after release so requests never glue together
	task automatic bus_write(input logic [5:0] a, input logic [31:0] d);
		logic [31:0] ignored;
		avs_address   <= a;
		avs_writedata <= d;
		avs_write     <= 1'b1;
		finish_req(ignored);
		@(posedge clk);
	endtask

	// one read; data stands at the completing edge and is taken there
	task automatic bus_read(input logic [5:0] a, output logic [31:0] d);
		avs_address <= a;
		avs_read    <= 1'b1;
		finish_req(d);
		@(posedge clk);
	endtask
endmodule // psd_host_model
`default_nettype wire

// *** tb/psd_core_bench.sv ***
// self-checking bench for the status and display configuration block
`default_nettype none
module psd_core_bench;
	import psd_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;

	logic        clk;
	logic        reset;
	psd_cond_t   cond;
	logic        seq_auto_red, seq_auto_green, seq_auto_blue;
	logic [5:0]  avs_address;
	logic        avs_read, avs_write, avs_waitrequest;
	logic [31:0] avs_writedata, avs_readdata;
	logic [3:0]  avs_byteenable;
	logic        flip_long_axis, flip_short_axis, force_swap, invert_data, dual_pixel;
	logic        rx_connector, rx_power_down, rx_out_en_n;
	logic [2:0]  light_enable;
	logic [1:0]  input_port;
	psd_rgb_t    light_current, tp_foreground, tp_background;
	psd_source_t display_source;
	psd_mode_t   op_mode;
	psd_swap_t   channel_swap;
	psd_window_t disp_window, crop_window;
	int          mismatches;
	int          samples_checked;
	int          cycles;

	////////////////////////////////////////////////////////////////////////////////
	psd_core psd_core_i (.clk(clk), .reset(reset), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .cond(cond), .seq_auto_red(seq_auto_red),
		.seq_auto_green(seq_auto_green), .seq_auto_blue(seq_auto_blue),
		.flip_long_axis(flip_long_axis), .flip_short_axis(flip_short_axis),
		.force_swap(force_swap), .light_enable(light_enable), .light_current(light_current),
		.invert_data(invert_data), .display_source(display_source), .op_mode(op_mode),
		.input_port(input_port), .channel_swap(channel_swap), .dual_pixel(dual_pixel),
		.tp_foreground(tp_foreground), .tp_background(tp_background),
		.disp_window(disp_window), .crop_window(crop_window), .rx_connector(rx_connector),
		.rx_power_down(rx_power_down), .rx_out_en_n(rx_out_en_n));
	psd_host_model psd_host_model_i (.clk(clk), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest));

	////////////////////////////////////////////////////////////////////////////////
	// 100 MHz clock and a cycle ceiling well above the expected run length
	initial clk = 1'b0;
	always #5 clk = ~clk;
	initial cycles = 0;
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			mismatches++;
			conclude();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] expd);
		samples_checked++;
		if (seen !== expd)
		begin
			mismatches++;
			$display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, expd);
		end
	endtask
	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		psd_host_model_i.bus_write(a, d);
	endtask
	task automatic rdc(input logic [5:0] a, input logic [31:0] expd);
		logic [31:0] d;
		psd_host_model_i.bus_read(a, d);
		check(d, expd);
	endtask
	task automatic note(input string s);
		$display("test done: %s", s);
	endtask
	// hold a condition, read status, drop it; sticky and memtest bits must persist
	task automatic stat(input psd_cond_t c, input logic [31:0] e);
		cond <= c;
		@(posedge clk);
		rdc(OFS_STATUS, e);
		check(32'(force_swap), 32'(e[ST_FSWAP]));
		cond <= '0;
		@(posedge clk);
		rdc(OFS_STATUS, e & 32'h0000_00F1);
		wr(OFS_CLEAR, 32'h0000_00F0);
	endtask
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial
	begin
		mismatches = 0;
		samples_checked = 0;
		reset = 1'b1;
		cond = '0;
		seq_auto_red = 1'b0;
		seq_auto_green = 1'b0;
		seq_auto_blue = 1'b0;
		repeat (4) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		rdc(OFS_LIGHT, 32'h0000_000F);
		rdc(OFS_CURRENT, 32'h0064_6464);
		rdc(OFS_PORTCFG, 32'h0000_0004);
		rdc(OFS_STATUS, 32'h0000_0000);
		note("reset values");
		stat(17'h18000, 32'h0000_0001);
		stat(17'h08000, 32'h0000_0000);
		stat(17'h04000, 32'h0000_0002);
		stat(17'h02000, 32'h0000_0002);
		stat(17'h01000, 32'h0000_0000);
		stat(17'h01800, 32'h0000_0004);
		stat(17'h00400, 32'h0000_0000);
		stat(17'h00600, 32'h0000_0008);
		stat(17'h00100, 32'h0000_0010);
		stat(17'h00080, 32'h0000_0020);
		stat(17'h00020, 32'h0000_0040);
		stat(17'h00010, 32'h0000_0080);
		stat(17'h00008, 32'h0000_0100);
		stat(17'h00004, 32'h0000_0200);
		stat(17'h00002, 32'h0000_0400);
		stat(17'h00001, 32'h0000_0800);
		note("status flags");
		wr(OFS_MODE, 32'h0000_0002);
		check(32'(op_mode), 32'(PSD_MODE_VIDEO));
		rdc(OFS_STATUS, 32'h0000_1000);
		cond <= 17'h00001;
		wr(OFS_MODE, 32'h0000_0002);
		check(32'(op_mode), 32'(PSD_MODE_VIDPAT));
		rdc(OFS_STATUS, 32'h0000_0800);
		cond <= 17'h00041;
		@(posedge clk);
		rdc(OFS_STATUS, 32'h0000_0820);
		cond <= 17'h00001;
		wr(OFS_CLEAR, 32'h0000_00F0);
		for (int m = 0; m < 4; m++)
		begin
			wr(OFS_MODE, 32'(m));
			check(32'(op_mode), 32'(m));
		end
		wr(OFS_MODE, 32'h0000_0000);
		cond <= '0;
		note("mode switch");
		for (int s = 0; s < 4; s++)
		begin
			wr(OFS_SOURCE, 32'(s));
			check(32'(display_source), 32'(s));
		end
		// sequencer stays stopped while data inversion is programmed
		wr(OFS_ORIENT, 32'h0000_0007);
		check(32'({invert_data, flip_short_axis, flip_long_axis}), 32'h7);
		wr(OFS_LIGHT, 32'h0000_0015);
		check(32'(light_enable), 32'h5);
		rdc(OFS_LIGHT, 32'h0000_0015);
		check(32'(light_current), 32'h009B_9B9B);
		rdc(OFS_CURRENT, 32'h0064_6464);
		seq_auto_red <= 1'b1;
		seq_auto_green <= 1'b1;
		wr(OFS_LIGHT, 32'h0000_0008);
		check(32'(light_enable), 32'h3);
		wr(OFS_CURRENT, 32'h000A_0B0C);
		check(32'(light_current), 32'h000A_0B0C);
		note("orientation and light");
		for (int w = 0; w < 6; w++)
		begin
			wr(OFS_PORTCFG, 32'h0000_00E1 | 32'(w << 2));
			check(32'(channel_swap), 32'(w));
		end
		check(32'({rx_power_down, rx_out_en_n, rx_connector, dual_pixel, input_port}),
			32'h3D);
		wr(OFS_PORTCFG, 32'h0000_00F9);
		check(32'(channel_swap), 32'(PSD_SWAP_CAB));
		wr(OFS_PORTCFG, 32'h0000_0004);
		check(32'({rx_power_down, rx_out_en_n, dual_pixel}), 32'h0);
		note("port config");
		wr(OFS_TP_FORE, 32'h0011_2233);
		wr(OFS_TP_BACK, 32'h0044_5566);
		check(32'(tp_foreground), 32'h0011_2233);
		check(32'(tp_background), 32'h0044_5566);
		wr(OFS_DISP_H, 32'h0010_0780);
		wr(OFS_CROP_V, 32'h0004_0438);
		check({disp_window.start_pixel, disp_window.pixels_per_line}, 32'h0010_0780);
		check({crop_window.start_line, crop_window.lines_per_frame}, 32'h0004_0438);
		wr(6'h3C, 32'hFFFF_FFFF);
		rdc(6'h3C, 32'h0000_0000);
		rdc(6'h38, 32'h0000_0000);
		note("pattern, windows, unmapped");
		conclude();
	end
endmodule // psd_core_bench
`default_nettype wire
